//--- bench/flash_host.sv
// host controller model for the serial link of the flash block
`timescale 1ns/100ps
module flash_host (
  // link pins
  output logic            sck,
  output logic            cs_n,
  output logic            hold_n,
  output logic [3:0]      io_drv,
  output logic [3:0]      io_en,
  // resolved pin levels and device enables
  input  wire logic [3:0] io_pin,
  input  wire logic [3:0] dev_oe
);
  logic [7:0] rx_byte;
  logic       mode3;
  int         float_errs;
  event       got;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    io_drv = 4'h0;
    io_en = 4'h0;
    rx_byte = 8'h00;
    mode3 = 1'b0;
    float_errs = 0;
  end

  // one frame: tx bytes out, then nrd bytes in; optional pause
  task automatic frame(input logic [7:0] tx[$], input int nrd,
                       input bit quad, input int hold_at);
    logic [7:0] sh;
    logic [7:0] rx;
    int         bits;
    bits = 0;
    rx = 8'h00;
    #7.3;
    sck = mode3;
    // idle level settles while still deselected
    #40;
    cs_n = 1'b0;
    #80;
    for (int k = 0; k < tx.size() + nrd; k++) begin
      sh = (k < tx.size()) ? tx[k] : 8'h00;
      for (int b = 0; b < (quad ? 2 : 8); b++) begin
        sck = 1'b0;
        io_en = (k >= tx.size()) ? 4'h0 : (quad ? 4'hF : 4'h1);
        io_drv = quad ? sh[7:4] : {3'h0, sh[7]};
        sh = quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
        #80;
        sck = 1'b1;
        rx = quad ? {rx[3:0], io_pin} : {rx[6:0], io_pin[1]};
        if (bits == hold_at)
          hold_n = 1'b0;
        bits++;
        #80;
        if (!hold_n) begin
          repeat (3) begin
            sck = 1'b0;
            #80;
            sck = 1'b1;
            if (dev_oe !== 4'h0)
              float_errs++;
            #80;
          end
          hold_n = 1'b1;
        end
      end
      if (k >= tx.size()) begin
        rx_byte = rx;
        -> got;
      end
    end
    sck = mode3;
    #80;
    cs_n = 1'b1;
    io_en = 4'h0;
    #120;
  endtask
endmodule

//--- bench/tb.sv
// self-checking bench for the flash protection block
`timescale 1ns/100ps
module tb;
  import flash_prot_pkg::*;
  logic        clk;
  logic        rst;
  logic        nv_rst;
  logic        wp_n;
  logic        flt;
  logic        sck;
  logic        cs_n;
  logic        hold_n;
  logic [3:0]  pin_io;
  logic [3:0]  h_io;
  logic [3:0]  h_en;
  pins_in_t    pins;
  pins_out_t   drv;
  mem_req_t    req;
  logic [23:0] maddr;
  logic [7:0]  rdata;
  logic [7:0]  exp_q[$];
  logic [33:0] prog_q[$];
  int          num_errors;
  int          num_checks;
  int          cycles;
  int          seed;
  logic [47:0] v;
  logic [7:0]  d;

  assign pins = {cs_n, wp_n, hold_n, pin_io};
  assign rdata = maddr[7:0] ^ maddr[15:8] ^ 8'h3C;
  assign pin_io = (drv.oe & drv.io) | (~drv.oe & h_en & h_io)
                | (~drv.oe & ~h_en & {4{flt}});

  flash_protect dut (
    .clk          (clk),
    .rst          (rst),
    .nv_rst       (nv_rst),
    .sck          (sck),
    .serial_pins  (pins),
    .serial_drive (drv),
    .mem_req      (req),
    .mem_addr     (maddr),
    .mem_rdata    (rdata)
  );

  flash_host hst (
    .sck    (sck),
    .cs_n   (cs_n),
    .hold_n (hold_n),
    .io_drv (h_io),
    .io_en  (h_en),
    .io_pin (pin_io),
    .dev_oe (drv.oe)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic fail(input string msg);
    num_errors++;
    $display("ERROR t=%0t %s", $time, msg);
  endtask

  task automatic compare(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp)
      fail($sformatf("got %h exp %h", got, exp));
  endtask

  task automatic final_report;
    compare(exp_q.size(), 0);
    compare(prog_q.size(), 0);
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    flt <= ~flt;
    cycles++;
    if (cycles == 40000) begin
      fail("timeout");
      final_report();
    end
  end

  // read bytes and program requests are matched against notes
  always @(hst.got) begin
    if (exp_q.size() == 0)
      fail("unexpected byte");
    else
      compare(hst.rx_byte, exp_q.pop_front());
  end

  always @(posedge clk) begin
    if (req.prog === 1'b1 || req.erase === 1'b1) begin
      if (prog_q.size() == 0)
        fail("unexpected program");
      else
        compare({req.erase, req.sid, req.addr,
                 req.erase ? 8'h00 : req.data}, prog_q.pop_front());
    end
  end

  task automatic send(input logic [7:0] cmd, input logic [47:0] val,
                      input int n, input int nrd = 0,
                      input bit quad = 0, input int hold_at = -1);
    logic [7:0] q[$];
    q.push_back(cmd);
    for (int i = n - 1; i >= 0; i--)
      q.push_back(val[8*i+:8]);
    hst.frame(q, nrd, quad, hold_at);
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [47:0] val,
                    input int n, input bit quad = 0,
                    input int hold_at = -1);
    for (int i = n - 1; i >= 0; i--)
      exp_q.push_back(val[8*i+:8]);
    send(cmd, 48'h0, 0, n, quad, hold_at);
  endtask

  task automatic write_enable_cmd;
    send(CMD_WRITE_ENABLE, 48'h0, 0);
  endtask

  task automatic done(input string name);
    $display("test %s finished, errors %0d", name, num_errors);
  endtask

  initial begin
    seed = 56079;
    rst = 1'b1;
    nv_rst = 1'b1;
    wp_n = 1'b1;
    flt = 1'b0;
    cycles = 0;
    num_errors = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    nv_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(CMD_READ_STATUS, 48'h00, 1);
    rd(CMD_READ_CONFIG, 48'h08, 1);
    rd(CMD_READ_PROT, 48'h5555_FFFF_FFFF, 6);
    done("reset");
    v = 48'({$random(seed), $random(seed)});
    send(CMD_WRITE_PROT, v, 6);
    rd(CMD_READ_PROT, 48'h5555_FFFF_FFFF, 6);
    write_enable_cmd();
    send(CMD_WRITE_PROT, v, 6);
    rd(CMD_READ_PROT, v, 6);
    write_enable_cmd();
    send(CMD_WRITE_PROT, 48'h0002_0000_0000, 6);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    send(CMD_FAST_READ, 48'h0, 4, 2);
    exp_q.push_back(8'h3C);
    exp_q.push_back(8'h3D);
    send(CMD_FAST_READ, 48'h0100_0000, 4, 2);
    write_enable_cmd();
    send(CMD_WRITE_PROT, 48'hFFFF_FFFF_FFFF, 6);
    write_enable_cmd();
    send(CMD_GLOBAL_UNLOCK, 48'h0, 0);
    rd(CMD_READ_PROT, 48'hAAAA_0000_0000, 6);
    done("block bits");
    write_enable_cmd();
    send(CMD_WRITE_STATUS, 48'h0082, 2);
    rd(CMD_READ_CONFIG, 48'h8A, 1);
    @(posedge clk);
    wp_n <= 1'b0;
    write_enable_cmd();
    send(CMD_WRITE_PROT, 48'h1, 6);
    rd(CMD_READ_PROT, 48'h1, 6);
    write_enable_cmd();
    send(CMD_WRITE_STATUS, 48'h0080, 2);
    rd(CMD_READ_CONFIG, 48'h88, 1);
    write_enable_cmd();
    send(CMD_WRITE_PROT, 48'h0, 6);
    rd(CMD_READ_PROT, 48'h1, 6);
    write_enable_cmd();
    send(CMD_WRITE_STATUS, 48'h0, 2);
    rd(CMD_READ_CONFIG, 48'h88, 1);
    d = 8'($random(seed));
    prog_q.push_back({2'b00, 24'h020000, d});
    write_enable_cmd();
    send(CMD_PROGRAM, {24'h020000, d}, 4);
    write_enable_cmd();
    send(CMD_PROGRAM, {24'h010000, d}, 4);
    prog_q.push_back({2'b10, 24'h020000, 8'h00});
    write_enable_cmd();
    send(CMD_SECTOR_ERASE, 48'h02_0000, 3);
    write_enable_cmd();
    send(CMD_SECTOR_ERASE, 48'h01_0000, 3);
    @(posedge clk);
    wp_n <= 1'b1;
    done("protect pin");
    write_enable_cmd();
    send(CMD_WRITE_PERM, 48'h01_0000_0000, 5);
    rd(CMD_READ_PROT, 48'h0001_0000_0001, 6);
    rd(CMD_READ_CONFIG, 48'h80, 1);
    write_enable_cmd();
    send(CMD_GLOBAL_UNLOCK, 48'h0, 0);
    write_enable_cmd();
    send(CMD_WRITE_PERM, 48'h0, 5);
    write_enable_cmd();
    send(CMD_WRITE_PROT, 48'h0, 6);
    rd(CMD_READ_PROT, 48'h0001_0000_0000, 6);
    done("permanent lock");
    rd(CMD_READ_PROT, 48'h0001_0000_0000, 6, 0, 4);
    rd(CMD_READ_PROT, 48'h0001_0000_0000, 6, 0, 30);
    compare(hst.float_errs, 0);
    done("pause");
    send(CMD_QUAD_ENTER, 48'h0, 0);
    rd(CMD_READ_STATUS, 48'h00, 1, 1);
    rd(CMD_READ_PROT, 48'h0001_0000_0000, 6, 1);
    send(CMD_QUAD_EXIT, 48'h0, 0, 0, 1);
    rd(CMD_READ_STATUS, 48'h00, 1);
    done("quad");
    write_enable_cmd();
    send(CMD_LOCKDOWN, 48'h0, 0);
    rd(CMD_READ_STATUS, 48'h10, 1);
    write_enable_cmd();
    send(CMD_WRITE_PROT, 48'hFFFF_FFFF_FFFF, 6);
    write_enable_cmd();
    send(CMD_WRITE_PERM, 48'h02_0000_0000, 5);
    rd(CMD_READ_PROT, 48'h0001_0000_0000, 6);
    done("lockdown");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    hst.mode3 = 1'b1;
    rd(CMD_READ_STATUS, 48'h00, 1);
    rd(CMD_READ_CONFIG, 48'h80, 1);
    write_enable_cmd();
    send(CMD_GLOBAL_UNLOCK, 48'h0, 0);
    rd(CMD_READ_PROT, 48'h0001_0000_0000, 6);
    write_enable_cmd();
    rd(CMD_READ_STATUS, 48'h02, 1);
    send(CMD_WRITE_DISABLE, 48'h0, 0);
    rd(CMD_READ_STATUS, 48'h00, 1);
    d = 8'($random(seed));
    prog_q.push_back({2'b01, 24'h000010, d});
    write_enable_cmd();
    send(CMD_PROGRAM_SID, {24'h000010, d}, 4);
    write_enable_cmd();
    send(CMD_LOCKOUT_SID, 48'h0, 0);
    rd(CMD_READ_STATUS, 48'h20, 1);
    write_enable_cmd();
    send(CMD_PROGRAM_SID, {24'h000020, d}, 4);
    done("power cycle");
    final_report();
  end
endmodule

//--- rtl/bit_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

//--- rtl/flash_prot_pkg.sv
// constants and types of the serial flash protection block
package flash_prot_pkg;
  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h05;
  localparam logic [7:0] CMD_READ_CONFIG   = 8'h35;
  localparam logic [7:0] CMD_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] CMD_READ_PROT     = 8'h72;
  localparam logic [7:0] CMD_WRITE_PROT    = 8'h42;
  localparam logic [7:0] CMD_LOCKDOWN      = 8'h8D;
  localparam logic [7:0] CMD_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] CMD_WRITE_PERM    = 8'hE8;
  localparam logic [7:0] CMD_PROGRAM_SID   = 8'hA5;
  localparam logic [7:0] CMD_LOCKOUT_SID   = 8'h85;
  localparam logic [7:0] CMD_QUAD_ENTER    = 8'h38;
  localparam logic [7:0] CMD_QUAD_EXIT     = 8'hFF;
  localparam logic [7:0] CMD_FAST_READ     = 8'h0B;
  localparam logic [7:0] CMD_PROGRAM       = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE  = 8'h20;

  // status and configuration bit positions
  localparam int STAT_WEL_BIT      = 1;
  localparam int STAT_LOCKDOWN_BIT = 4;
  localparam int STAT_SID_BIT      = 5;
  localparam int CFG_IOC_BIT       = 1;
  localparam int CFG_NOPERM_BIT    = 3;
  localparam int CFG_PIN_EN_BIT    = 7;

  // protection layout
  localparam int ADDR_W     = 24;
  localparam int PROT_W     = 48;
  localparam int PERM_W     = 40;
  localparam int N_OVL      = 32;
  localparam int PROT_BYTES = 6;
  localparam int PERM_BYTES = 5;
  localparam int CFG_BYTES  = 2;
  localparam int ADDR_BYTES = 3;
  localparam logic [PROT_W-1:0] PROT_WLOCK_MASK = 48'h5555_FFFF_FFFF;
  localparam logic [PROT_W-1:0] PROT_RESET      = 48'h5555_FFFF_FFFF;

  // security identifier space
  localparam logic [ADDR_W-1:0] SID_USER_LO = 24'h000008;
  localparam logic [ADDR_W-1:0] SID_SIZE    = 24'h000800;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_OPCODE = 3'h2,
    ST_BODY   = 3'h4
  } frame_st_t;

  typedef struct packed {
    logic       cs_n;
    logic       wp_n;
    logic       hold_n;
    logic [3:0] io;
  } pins_in_t;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] oe;
  } pins_out_t;

  typedef struct packed {
    logic              prog;
    logic              erase;
    logic              sid;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } mem_req_t;
endpackage

//--- rtl/flash_protect.sv
// protection, mode and pause logic of a serial flash device
`timescale 1ns/100ps
// Contract
// - sectors plus 8 param, 2 half, 30 full blocks
// - single-line after reset, command enters quad mode
// - idle clock low or high both work
// - sample on rising edge, drive after falling edge
// - all blocks write-locked after power-on reset
// - protection register 48 bits, pairs for params
// - one means locked, pair msb is read-lock
// - reads of read-locked parameter block return zero
// - global unlock clears every write-lock bit
// - lock-down needs write-enable, blocks protection changes
// - permanent lock register 40 bits, one per block
// - permanent one locks forever, zero does nothing
// - permanent lock write ignored during lock-down
// - pin works only single/dual, io config zero
// - pin-enable bit nonvolatile, factory zero
// - low pin blocks protection and configuration writes
// - lock-down blocks protection writes regardless of pin
// - protect pin never affects program or erase
// - security id factory part read-only, lockable
// - pause only single/dual, output floats, keeps position
// - pause starts and ends at low clock phase
// - chip select high resets link, pause persists
// - lock-down status at status bit four
module flash_protect (
  // system clock, power-on and factory resets
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      nv_rst,
  // serial link
  input  wire logic                      sck,
  input  wire flash_prot_pkg::pins_in_t  serial_pins,
  output      flash_prot_pkg::pins_out_t serial_drive,
  // array side
  output      flash_prot_pkg::mem_req_t  mem_req,
  output      logic [23:0]               mem_addr,
  input  wire logic [7:0]                mem_rdata
);
  import flash_prot_pkg::*;

  // link side state
  logic       link_rst;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic       first_q;
  logic       last_bit;
  logic [7:0] rx_q;
  logic       rx_tgl_q;
  logic       quad_q;
  logic       pause_q;
  logic       hold_en_s;
  logic [3:0] out_q;
  logic       oe_q;

  // system side state
  logic [3:0]        s_q;
  logic              cs_s;
  logic              wp_s;
  logic              tgl_s;
  logic              quad_s;
  logic              cs_prev_q;
  logic              seen_q;
  logic              byte_ev;
  logic              frame_end;
  logic              frame_start;
  logic              commit;
  frame_st_t         st_q;
  logic [7:0]        op_q;
  logic [3:0]        cnt_q;
  logic [PROT_W-1:0] shift_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        tx_q;
  logic              tx_en_q;
  logic [7:0]        nxt_q;
  logic              wel_q;
  logic              lockdown_q;
  logic              ioc_q;
  logic [PROT_W-1:0] bpr_q;
  logic [PERM_W-1:0] pl_q;
  logic              pin_en_q;
  logic              sid_lock_q;
  logic [PROT_W-1:0] force_w;
  logic [PROT_W-1:0] bpr_rd;
  logic              wp_active;
  logic              prot_ok;
  logic [5:0]        blk_idx;
  logic              blk_param;
  logic              rd_locked;
  logic              wr_locked;
  logic              sid_ok;
  logic [7:0]        status;
  logic [7:0]        cfg_rd;

  // block index of an address; pairs of params sit above the 32 others
  function automatic logic [5:0] prot_idx(input logic [ADDR_W-1:0] a);
    logic [4:0] seg;
    seg = a[20:16];
    if (seg == 5'h00) begin
      prot_idx = a[15] ? 6'h1E : {3'h4, a[14:13], 1'b0};
    end else if (seg == 5'h1F) begin
      prot_idx = a[15] ? {3'h5, a[14:13], 1'b0} : 6'h1F;
    end else begin
      prot_idx = {1'b0, 5'(seg - 5'h01)};
    end
  endfunction

  function automatic logic is_param(input logic [ADDR_W-1:0] a);
    is_param = (a[20:16] == 5'h00 && !a[15]) ||
               (a[20:16] == 5'h1F && a[15]);
  endfunction

  // ---------------- link clock domain ----------------
  assign link_rst = rst | serial_pins.cs_n;
  assign last_bit = quad_q ? (bit_q == 3'h1) : (bit_q == 3'h7);
  assign sh_d     = quad_q ? {sh_q[3:0], serial_pins.io}
                           : {sh_q[6:0], serial_pins.io[0]};

  bit_sync #(.W(1)) u_sync_link (
    .clk (sck),
    .rst (rst),
    .d   (~ioc_q & ~quad_q),
    .q   (hold_en_s)
  );

  // bit position restarts with every frame
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      bit_q   <= 3'h0;
      sh_q    <= 8'h00;
      first_q <= 1'b1;
    end else if (!pause_q) begin
      sh_q <= sh_d;
      if (last_bit) begin
        bit_q   <= 3'h0;
        first_q <= 1'b0;
      end else begin
        bit_q <= bit_q + 3'h1;
      end
    end
  end

  // completed byte and mode survive the end of frame
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      rx_q     <= 8'h00;
      rx_tgl_q <= 1'b0;
      quad_q   <= 1'b0;
    end else if (!serial_pins.cs_n && !pause_q && last_bit) begin
      rx_q     <= sh_d;
      rx_tgl_q <= ~rx_tgl_q;
      if (first_q && !quad_q && sh_d == CMD_QUAD_ENTER) begin
        quad_q <= 1'b1;
      end else if (first_q && quad_q && sh_d == CMD_QUAD_EXIT) begin
        quad_q <= 1'b0;
      end
    end
  end

  // drive after the falling edge; tx_q is settled by then
  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      out_q <= 4'h0;
      oe_q  <= 1'b0;
    end else if (!pause_q) begin
      oe_q <= tx_en_q;
      if (quad_q) begin
        out_q <= bit_q[0] ? tx_q[3:0] : tx_q[7:4];
      end else begin
        out_q <= {2'b00, tx_q[3'h7 - bit_q], 1'b0};
      end
    end
  end

  // pause follows the pin only in low clock phases
  always_ff @(negedge sck or posedge rst) begin
    if (rst) begin
      pause_q <= 1'b0;
    end else begin
      pause_q <= hold_en_s & ~serial_pins.hold_n &
                 (~serial_pins.cs_n | pause_q);
    end
  end

  assign serial_drive.io = out_q;
  assign serial_drive.oe = (oe_q & ~pause_q & ~serial_pins.cs_n) ?
                           (quad_q ? 4'hF : 4'h2) : 4'h0;

  // ---------------- system clock domain ----------------
  bit_sync #(.W(4)) u_sync_sys (
    .clk (clk),
    .rst (rst),
    .d   ({~serial_pins.cs_n, ~serial_pins.wp_n, rx_tgl_q, quad_q}),
    .q   (s_q)
  );

  // pins pass inverted so the synchroniser's reset reads as idle
  assign cs_s        = ~s_q[3];
  assign wp_s        = ~s_q[2];
  assign tgl_s       = s_q[1];
  assign quad_s      = s_q[0];
  assign byte_ev     = tgl_s ^ seen_q;
  assign frame_end   = cs_s & ~cs_prev_q;
  assign frame_start = ~cs_s & cs_prev_q;
  assign commit      = frame_end & (st_q == ST_BODY);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_prev_q <= 1'b1;
      seen_q    <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      seen_q    <= tgl_s;
    end
  end

  // forced write-locks from the permanent register
  genvar gi;
  generate
    for (gi = 0; gi < PERM_W; gi++) begin : g_force
      if (gi < N_OVL) begin : g_ovl
        assign force_w[gi] = pl_q[gi];
      end else begin : g_par
        assign force_w[N_OVL + 2*(gi-N_OVL)]     = pl_q[gi];
        assign force_w[N_OVL + 2*(gi-N_OVL) + 1] = 1'b0;
      end
    end
  endgenerate

  assign bpr_rd    = bpr_q | force_w;
  assign wp_active = pin_en_q & ~ioc_q & ~quad_s & ~wp_s;
  assign prot_ok   = ~lockdown_q & ~wp_active;
  assign blk_idx   = prot_idx(addr_q);
  assign blk_param = is_param(addr_q);
  assign rd_locked = blk_param & bpr_rd[blk_idx + 6'h01];
  assign wr_locked = bpr_rd[blk_idx];
  assign sid_ok    = wel_q & ~sid_lock_q & (addr_q >= SID_USER_LO) &
                     (addr_q < SID_SIZE);
  assign mem_addr  = addr_q;

  always_comb begin
    status                    = 8'h00;
    status[STAT_WEL_BIT]      = wel_q;
    status[STAT_LOCKDOWN_BIT] = lockdown_q;
    status[STAT_SID_BIT]      = sid_lock_q;
    cfg_rd                    = 8'h00;
    cfg_rd[CFG_IOC_BIT]       = ioc_q;
    cfg_rd[CFG_NOPERM_BIT]    = ~|pl_q;
    cfg_rd[CFG_PIN_EN_BIT]    = pin_en_q;
  end

  // frame sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= ST_IDLE;
      op_q  <= 8'h00;
      cnt_q <= 4'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (frame_start) st_q <= ST_OPCODE;
        end
        ST_OPCODE: begin
          if (frame_end) begin
            st_q <= ST_IDLE;
          end else if (byte_ev) begin
            op_q  <= rx_q;
            cnt_q <= 4'h0;
            st_q  <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (frame_end) begin
            st_q <= ST_IDLE;
          end else if (byte_ev && cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // volatile protection state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel_q      <= 1'b0;
      lockdown_q <= 1'b0;
      ioc_q      <= 1'b0;
      bpr_q      <= PROT_RESET;
    end else if (commit) begin
      case (op_q)
        CMD_WRITE_ENABLE:  wel_q <= 1'b1;
        CMD_WRITE_DISABLE: wel_q <= 1'b0;
        CMD_WRITE_STATUS: begin
          wel_q <= 1'b0;
          if (wel_q && cnt_q == 4'(CFG_BYTES) && !wp_active) begin
            ioc_q <= shift_q[CFG_IOC_BIT];
          end
        end
        CMD_WRITE_PROT: begin
          wel_q <= 1'b0;
          if (wel_q && cnt_q == 4'(PROT_BYTES) && prot_ok) begin
            bpr_q <= shift_q;
          end
        end
        CMD_LOCKDOWN: begin
          wel_q <= 1'b0;
          if (wel_q) lockdown_q <= 1'b1;
        end
        CMD_GLOBAL_UNLOCK: begin
          wel_q <= 1'b0;
          if (wel_q && prot_ok) begin
            bpr_q <= bpr_q & ~PROT_WLOCK_MASK;
          end
        end
        CMD_WRITE_PERM, CMD_LOCKOUT_SID, CMD_PROGRAM,
        CMD_PROGRAM_SID, CMD_SECTOR_ERASE: wel_q <= 1'b0;
        default: wel_q <= wel_q;
      endcase
    end
  end

  // nonvolatile bits, kept through the power-on reset, cleared by the factory reset
  always_ff @(posedge clk or posedge nv_rst) begin
    if (nv_rst) begin
      pl_q       <= '0;
      pin_en_q   <= 1'b0;
      sid_lock_q <= 1'b0;
    end else if (commit && wel_q) begin
      case (op_q)
        CMD_WRITE_STATUS: begin
          if (cnt_q == 4'(CFG_BYTES) && !wp_active) begin
            pin_en_q <= shift_q[CFG_PIN_EN_BIT];
          end
        end
        CMD_WRITE_PERM: begin
          if (cnt_q == 4'(PERM_BYTES) && !lockdown_q) begin
            pl_q <= pl_q | shift_q[PERM_W-1:0];
          end
        end
        CMD_LOCKOUT_SID: sid_lock_q <= 1'b1;
        default: sid_lock_q <= sid_lock_q;
      endcase
    end
  end

  // byte stream: argument assembly, reply bytes and array requests
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
      addr_q  <= '0;
      tx_q    <= 8'h00;
      tx_en_q <= 1'b0;
      nxt_q   <= 8'h00;
      mem_req <= '0;
    end else begin
      mem_req.prog  <= 1'b0;
      mem_req.erase <= 1'b0;
      nxt_q         <= rd_locked ? 8'h00 : mem_rdata;
      if (commit && op_q == CMD_SECTOR_ERASE && wel_q &&
          cnt_q == 4'(ADDR_BYTES) && !wr_locked) begin
        mem_req.erase <= 1'b1;
        mem_req.sid   <= 1'b0;
        mem_req.addr  <= addr_q;
      end
      if (frame_end) begin
        tx_en_q <= 1'b0;
      end else if (byte_ev && st_q == ST_OPCODE) begin
        shift_q <= {shift_q[PROT_W-9:0], rx_q};
        case (rx_q)
          CMD_READ_STATUS: begin
            tx_q    <= status;
            tx_en_q <= 1'b1;
          end
          CMD_READ_CONFIG: begin
            tx_q    <= cfg_rd;
            tx_en_q <= 1'b1;
          end
          CMD_READ_PROT: begin
            tx_q    <= bpr_rd[PROT_W-1 -: 8];
            shift_q <= {bpr_rd[PROT_W-9:0], 8'h00};
            tx_en_q <= 1'b1;
          end
          default: tx_en_q <= 1'b0;
        endcase
      end else if (byte_ev && st_q == ST_BODY) begin
        shift_q <= {shift_q[PROT_W-9:0], rx_q};
        if (cnt_q < 4'(ADDR_BYTES)) begin
          addr_q <= {addr_q[ADDR_W-9:0], rx_q};
        end
        case (op_q)
          CMD_READ_PROT: begin
            tx_q    <= shift_q[PROT_W-1 -: 8];
            shift_q <= {shift_q[PROT_W-9:0], 8'h00};
          end
          CMD_FAST_READ: begin
            if (cnt_q >= 4'(ADDR_BYTES)) begin
              tx_q    <= nxt_q;
              tx_en_q <= 1'b1;
              addr_q  <= addr_q + 24'h000001;
            end
          end
          CMD_PROGRAM, CMD_PROGRAM_SID: begin
            if (cnt_q >= 4'(ADDR_BYTES)) begin
              addr_q        <= addr_q + 24'h000001;
              mem_req.addr  <= addr_q;
              mem_req.data  <= rx_q;
              mem_req.sid   <= (op_q == CMD_PROGRAM_SID);
              mem_req.prog  <= (op_q == CMD_PROGRAM) ?
                               (wel_q & ~wr_locked) : sid_ok;
            end
          end
          default: tx_q <= tx_q;
        endcase
      end
    end
  end

  // ---------------- checks ----------------
  sequence s_prot_commit;
    commit && op_q == CMD_WRITE_PROT;
  endsequence

  sequence s_cfg_commit;
    commit && op_q == CMD_WRITE_STATUS;
  endsequence

  a_por_protect: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> bpr_q == PROT_RESET)
    else $error("write-locks not set after power-on reset");

  a_lock_sticky: assert property (@(posedge clk) disable iff (rst)
    lockdown_q |=> lockdown_q && status[STAT_LOCKDOWN_BIT])
    else $error("lock-down released without power cycle");

  a_lock_freeze: assert property (@(posedge clk) disable iff (rst)
    s_prot_commit ##0 lockdown_q |=> $stable(bpr_q))
    else $error("protection changed while locked down");

  a_pin_freeze: assert property (@(posedge clk)
    disable iff (rst || nv_rst)
    s_cfg_commit ##0 wp_active |=> $stable(ioc_q) && $stable(pin_en_q))
    else $error("configuration changed under protect pin");

  a_unlock_clears: assert property (@(posedge clk) disable iff (rst)
    commit && op_q == CMD_GLOBAL_UNLOCK && wel_q && prot_ok
    |=> (bpr_q & PROT_WLOCK_MASK) == '0)
    else $error("global unlock left write-locks set");

  a_perm_sticky: assert property (@(posedge clk)
    disable iff (rst || nv_rst)
    ##1 (pl_q & $past(pl_q)) == $past(pl_q) &&
    (bpr_rd & force_w) == force_w)
    else $error("permanent lock bit cleared");

  a_perm_ignored: assert property (@(posedge clk)
    disable iff (rst || nv_rst)
    commit && op_q == CMD_WRITE_PERM && lockdown_q |=> $stable(pl_q))
    else $error("permanent lock written during lock-down");

  a_wel_needed: assert property (@(posedge clk) disable iff (rst)
    !wel_q |=> $stable(bpr_q))
    else $error("protection changed without write-enable");

  a_readlock_zero: assert property (@(posedge clk) disable iff (rst)
    rd_locked ##1 rd_locked && $stable(addr_q) |-> nxt_q == 8'h00)
    else $error("read-locked block returned data");

  a_pause_float: assert property (@(posedge sck)
    disable iff (rst || serial_pins.cs_n)
    pause_q |-> serial_drive.oe == 4'h0 ##1 $stable(bit_q))
    else $error("output driven while paused");
endmodule
